/* src/instance_binding_handler.v */
// Instance binding handler: takes binding requests for one device class
// at a time, updates the instance-to-internal-address table, answers with
// an acknowledgement and one or more binding report frames.
// Assumes a frame controller that presents received payloads and takes
// outgoing frames with a valid/ready handshake.
`timescale 1ns/1ns
`default_nettype none
`include "binding_defines.vh"
// Summary of operation
// - Requests carry group 0x17C00 with target address in the low byte.
// - Binding support is optional; an enable input turns the handler off.
// - Payload byte 0 holds the device class code being configured.
// - Base instance 0xFF reports every instance of the class.
// - Max instance 0xFF updates only the base instance.
// - Base to max instance is an inclusive contiguous block.
// - Max 255 or max equal to base is a single assignment.
// - Base internal address 0xFFFF leaves mapping unchanged, reports only.
// - Internal address in bytes 3-4 selects mapped resources; bytes 5-6 are captured but never used.
// - Single-instance classes accept internal addresses of 0xFFFF.
// - Each request configures only the class code it names.
// - Same layout serves owned, commanded and monitored instances.
// - Every accepted request gets an ACK or a NAK.
// - At least one binding report follows each request.
// - Reports describe exactly the requested instances; a refused request gets one report, for its base instance only.
// - Without base instance, reports cover all instances of the class.
// - Reports use group 0x17B00 with destination in the low byte.
// - Report destination is never the global address 255.
// - Reports only answer requests, sent to the request source.
// - Report max 0xFF or max address 0xFFFF marks a single instance.
module instance_binding_handler (
   // Clock and reset
   input wire clk_sys_i,
   input wire resetn_i,
   // Configuration
   input wire enable_i,
   input wire [7:0] node_addr_i,
   input wire [7:0] device_class_code_i,
   input wire [7:0] inst_count_i,
   // Received frame
   input wire rx_valid_i,
   input wire [17:0] rx_message_group_number_i,
   input wire [7:0] rx_src_addr_i,
   input wire [63:0] rx_data_i,
   // Acknowledgement out
   output reg ack_valid_o,
   output reg ack_nak_o,
   output reg [7:0] ack_dest_o,
   input wire ack_ready_i,
   // Report frame out
   output reg tx_valid_o,
   output reg [17:0] tx_message_group_number_o,
   output reg [63:0] tx_data_o,
   input wire tx_ready_i,
   // Status
   output reg busy_o
);
   localparam [2:0] ST_IDLE = 3'd0;
   localparam [2:0] ST_WRITE = 3'd1;
   localparam [2:0] ST_ACK = 3'd2;
   localparam [2:0] ST_READ = 3'd3;
   localparam [2:0] ST_WAIT = 3'd4;
   localparam [2:0] ST_SEND = 3'd5;

   reg [2:0] state_ff;
   reg [7:0] src_ff;
   reg [7:0] cur_ff;
   reg [7:0] last_ff;
   reg [15:0] iaddr_ff;
   reg [15:0] max_iaddr_ff;
   reg single_ff;
   reg keep_ff;
   reg all_ff;
   reg nak_ff;
   // Start of the reported range, so the walk can rewind after writes
   reg [7:0] base_ff;
   // Class named by the request; refused classes are echoed back as such
   reg [7:0] class_ff;
   // Next-state values, settled by the decode process below
   reg [2:0] nxt_state;
   reg [7:0] nxt_src;
   reg [7:0] nxt_cur;
   reg [7:0] nxt_last;
   reg [7:0] nxt_base;
   reg [7:0] nxt_class;
   reg [15:0] nxt_iaddr;
   reg [15:0] nxt_max_iaddr;
   reg nxt_single;
   reg nxt_keep;
   reg nxt_all;
   reg nxt_nak;
   reg nxt_ack_valid;
   reg nxt_ack_nak;
   reg [7:0] nxt_ack_dest;
   reg nxt_tx_valid;
   reg [17:0] nxt_tx_group;
   reg [63:0] nxt_tx_data;
   reg nxt_busy;

   wire [7:0] req_class = rx_data_i[`B0_LSB+7:`B0_LSB];
   wire [7:0] req_base = rx_data_i[`B1_LSB+7:`B1_LSB];
   wire [7:0] req_max = rx_data_i[`B2_LSB+7:`B2_LSB];
   wire [15:0] req_base_ia = {rx_data_i[`B4_LSB+7:`B4_LSB],
                              rx_data_i[`B3_LSB+7:`B3_LSB]};
   wire [15:0] req_max_ia = {rx_data_i[`B6_LSB+7:`B6_LSB],
                             rx_data_i[`B5_LSB+7:`B5_LSB]};
   wire [17:0] req_group = `REQ_GROUP_BASE;
   wire [17:0] rpt_group = `RPT_GROUP_BASE;
   wire grp_hit = rx_message_group_number_i[`GROUP_HIGH_MSB:`GROUP_HIGH_LSB]
                  == req_group[`GROUP_HIGH_MSB:`GROUP_HIGH_LSB]
                  && rx_message_group_number_i[7:0] == node_addr_i;
   // A global source cannot be answered, so such frames are dropped
   wire take = enable_i && rx_valid_i && grp_hit && state_ff == ST_IDLE
               && rx_src_addr_i != `ADDR_GLOBAL;
   wire [7:0] last_inst = inst_count_i - 8'd1;
   // Request decode
   wire req_wrong = req_class != device_class_code_i
                    || inst_count_i == 8'd0;
   wire req_one = req_max == `INST_SINGLE || req_max == req_base;
   wire req_base_bad = req_base != `INST_ALL && req_base > last_inst;
   // Reversed or out-of-range block is refused
   wire req_block_bad = req_max < req_base || req_max > last_inst;

   wire [15:0] rd_addr;
   wire rd_bound;
   wire wr_en = state_ff == ST_WRITE && !keep_ff && !nak_ff;
   binding_table u_table (
      .clk_sys_i(clk_sys_i),
      .resetn_i(resetn_i),
      .wr_en_i(wr_en),
      .wr_inst_i(cur_ff),
      .wr_addr_i(iaddr_ff),
      .rd_inst_i(cur_ff),
      .rd_addr_o(rd_addr),
      .rd_bound_o(rd_bound)
   );

   // Unbound or refused entries carry the single-instance marks
   wire rpt_open = nak_ff || !rd_bound;
   wire rpt_single = rpt_open || (single_ff && !all_ff);
   wire [15:0] rpt_base_ia = rpt_open ? `IADDR_SINGLE : rd_addr;
   wire [15:0] rpt_max_ia = rpt_single ? `IADDR_SINGLE : rd_addr;
   wire [7:0] rpt_max_inst = rpt_single ? `INST_SINGLE : cur_ff;

   always @* begin
      nxt_state = state_ff;
      nxt_src = src_ff;
      nxt_cur = cur_ff;
      nxt_last = last_ff;
      nxt_base = base_ff;
      nxt_class = class_ff;
      nxt_iaddr = iaddr_ff;
      nxt_max_iaddr = max_iaddr_ff;
      nxt_single = single_ff;
      nxt_keep = keep_ff;
      nxt_all = all_ff;
      nxt_nak = nak_ff;
      nxt_ack_valid = ack_valid_o;
      nxt_ack_nak = ack_nak_o;
      nxt_ack_dest = ack_dest_o;
      nxt_tx_valid = tx_valid_o;
      nxt_tx_group = tx_message_group_number_o;
      nxt_tx_data = tx_data_o;
      nxt_busy = busy_o;
      case (state_ff)
         ST_IDLE: begin
            if (take) begin
               // Byte 7 of the request is never looked at
               nxt_src = rx_src_addr_i;
               nxt_class = req_class;
               nxt_busy = 1'b1;
               nxt_keep = req_base_ia == `IADDR_KEEP;
               nxt_iaddr = req_base_ia;
               nxt_max_iaddr = req_max_ia;
               nxt_all = 1'b0;
               nxt_nak = req_base_bad;
               nxt_cur = req_base;
               nxt_base = req_base;
               nxt_last = req_base;
               nxt_single = 1'b1;
               if (req_wrong) begin
                  // Other classes are refused, not mixed in
                  nxt_nak = 1'b1;
               end else if (req_base == `INST_ALL) begin
                  nxt_all = 1'b1;
                  nxt_keep = 1'b1;
                  nxt_cur = 8'h00;
                  nxt_base = 8'h00;
                  nxt_last = last_inst;
                  nxt_single = 1'b0;
               end else if (!req_one) begin
                  nxt_last = req_max;
                  nxt_single = 1'b0;
                  nxt_nak = req_base_bad || req_block_bad;
               end
               nxt_state = ST_WRITE;
            end
         end
         ST_WRITE: begin
            // One table entry per cycle; block gets consecutive addresses
            if (wr_en && cur_ff != last_ff) begin
               nxt_cur = cur_ff + 8'd1;
               nxt_iaddr = iaddr_ff + 16'd1;
            end else begin
               nxt_ack_valid = 1'b1;
               nxt_ack_nak = nak_ff;
               nxt_ack_dest = src_ff;
               nxt_state = ST_ACK;
            end
         end
         ST_ACK: begin
            if (ack_ready_i) begin
               nxt_ack_valid = 1'b0;
               // The write walk left the pointer at the end of the block
               nxt_cur = base_ff;
               nxt_state = ST_READ;
            end
         end
         ST_READ: begin
            // Table read has one cycle of latency
            nxt_state = ST_WAIT;
         end
         ST_WAIT: begin
            nxt_tx_valid = 1'b1;
            nxt_tx_group = {rpt_group[`GROUP_HIGH_MSB:`GROUP_HIGH_LSB],
                            src_ff};
            nxt_tx_data[`B0_LSB+7:`B0_LSB] = class_ff;
            nxt_tx_data[`B1_LSB+7:`B1_LSB] = cur_ff;
            nxt_tx_data[`B2_LSB+7:`B2_LSB] = rpt_max_inst;
            nxt_tx_data[`B3_LSB+15:`B3_LSB] = rpt_base_ia;
            nxt_tx_data[`B5_LSB+15:`B5_LSB] = rpt_max_ia;
            nxt_tx_data[`B7_LSB+7:`B7_LSB] = `RESERVED_FILL;
            nxt_state = ST_SEND;
         end
         ST_SEND: begin
            if (tx_ready_i) begin
               nxt_tx_valid = 1'b0;
               if (!nak_ff && cur_ff != last_ff) begin
                  nxt_cur = cur_ff + 8'd1;
                  nxt_state = ST_READ;
               end else begin
                  nxt_busy = 1'b0;
                  nxt_state = ST_IDLE;
               end
            end
         end
         default: begin
            nxt_state = ST_IDLE;
         end
      endcase
   end

   // Request context and walk pointers
   always @(posedge clk_sys_i) begin
      if (!resetn_i) begin
         state_ff <= ST_IDLE;
         src_ff <= 8'h00;
         cur_ff <= 8'h00;
         last_ff <= 8'h00;
         base_ff <= 8'h00;
         class_ff <= 8'h00;
         iaddr_ff <= 16'h0000;
         max_iaddr_ff <= 16'h0000;
         single_ff <= 1'b0;
         keep_ff <= 1'b0;
         all_ff <= 1'b0;
         nak_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         src_ff <= nxt_src;
         cur_ff <= nxt_cur;
         last_ff <= nxt_last;
         base_ff <= nxt_base;
         class_ff <= nxt_class;
         iaddr_ff <= nxt_iaddr;
         max_iaddr_ff <= nxt_max_iaddr;
         single_ff <= nxt_single;
         keep_ff <= nxt_keep;
         all_ff <= nxt_all;
         nak_ff <= nxt_nak;
      end
   end

   // Acknowledgement outputs
   always @(posedge clk_sys_i) begin
      if (!resetn_i) begin
         ack_valid_o <= 1'b0;
         ack_nak_o <= 1'b0;
         ack_dest_o <= 8'h00;
      end else begin
         ack_valid_o <= nxt_ack_valid;
         ack_nak_o <= nxt_ack_nak;
         ack_dest_o <= nxt_ack_dest;
      end
   end

   // Report outputs
   always @(posedge clk_sys_i) begin
      if (!resetn_i) begin
         tx_valid_o <= 1'b0;
         tx_message_group_number_o <= 18'h00000;
         tx_data_o <= 64'h0000000000000000;
      end else begin
         tx_valid_o <= nxt_tx_valid;
         tx_message_group_number_o <= nxt_tx_group;
         tx_data_o <= nxt_tx_data;
      end
   end

   // Busy spans the whole exchange; a second request arriving meanwhile is dropped, not held
   always @(posedge clk_sys_i) begin
      if (!resetn_i) begin
         busy_o <= 1'b0;
      end else begin
         busy_o <= nxt_busy;
      end
   end
endmodule // instance_binding_handler
`default_nettype wire

/* src/binding_defines.vh */
// Constants for the instance binding handler: group numbers, payload
// field positions, special values and mapping table size.
// Assumes a frame-level controller outside that parses and builds frames.
`ifndef BINDING_DEFINES_VH
`define BINDING_DEFINES_VH
`define REQ_GROUP_BASE 18'h17c00
`define RPT_GROUP_BASE 18'h17b00
`define GROUP_HIGH_MSB 17
`define GROUP_HIGH_LSB 8
`define ADDR_GLOBAL 8'hff
`define INST_ALL 8'hff
`define INST_SINGLE 8'hff
`define IADDR_KEEP 16'hffff
`define IADDR_SINGLE 16'hffff
`define RESERVED_FILL 8'hff
`define B0_LSB 0
`define B1_LSB 8
`define B2_LSB 16
`define B3_LSB 24
`define B4_LSB 32
`define B5_LSB 40
`define B6_LSB 48
`define B7_LSB 56
`define MAP_RESET 16'hffff
`define N_INST 256
`endif

/* src/binding_table.v */
// Instance binding table: one internal address per instance number.
// Assumes one writer and one reader, both on clk_sys_i.
`timescale 1ns/1ns
`default_nettype none
`include "binding_defines.vh"
module binding_table (
   // Clock and reset
   input wire clk_sys_i,
   input wire resetn_i,
   // Write port
   input wire wr_en_i,
   input wire [7:0] wr_inst_i,
   input wire [15:0] wr_addr_i,
   // Read port, one cycle latency
   input wire [7:0] rd_inst_i,
   output reg [15:0] rd_addr_o,
   output reg rd_bound_o
);
   reg [15:0] map_mem [0:`N_INST-1];
   reg [`N_INST-1:0] bound_ff;
   always @(posedge clk_sys_i) begin
      if (wr_en_i) begin
         map_mem[wr_inst_i] <= wr_addr_i;
      end
      rd_addr_o <= map_mem[rd_inst_i];
   end
   // Valid bits reset; memory content is only read where bound
   always @(posedge clk_sys_i) begin
      if (!resetn_i) begin
         bound_ff <= {`N_INST{1'b0}};
         rd_bound_o <= 1'b0;
      end else begin
         if (wr_en_i) begin
            bound_ff[wr_inst_i] <= 1'b1;
         end
         rd_bound_o <= bound_ff[rd_inst_i];
      end
   end
endmodule // binding_table
`default_nettype wire

/* testbench/binding_monitor.sv */
// Checker for the binding handler: handshakes, framing and replies.
// Assumes a bind onto instance_binding_handler; sees only its ports.
`timescale 1ns/1ns
`default_nettype none
module binding_monitor (
   // Clock, reset and setup
   input wire clk_sys_i,
   input wire resetn_i,
   input wire enable_i,
   input wire [7:0] node_addr_i,
   // Request and replies
   input wire rx_valid_i,
   input wire [17:0] rx_message_group_number_i,
   input wire [7:0] rx_src_addr_i,
   input wire ack_valid_o,
   input wire ack_nak_o,
   input wire [7:0] ack_dest_o,
   input wire ack_ready_i,
   input wire tx_valid_o,
   input wire [17:0] tx_message_group_number_o,
   input wire [63:0] tx_data_o,
   input wire tx_ready_i,
   input wire busy_o
);
   reg [7:0] src_ff;
   wire take = rx_valid_i && enable_i && !busy_o && rx_src_addr_i != 8'hff
      && rx_message_group_number_i == {10'h17c, node_addr_i};
   always @(posedge clk_sys_i)
      if (!resetn_i) src_ff <= 8'h00;
      else if (take) src_ff <= rx_src_addr_i;
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!resetn_i);
   sequence s_take; take; endsequence
   sequence s_ack_due; ##[2:300] ack_valid_o; endsequence
   property p_take_busy; s_take |=> busy_o; endproperty
   property p_ack_due; s_take |-> s_ack_due; endproperty
   property p_ack_hold; ack_valid_o && !ack_ready_i |=>
      ack_valid_o && $stable({ack_nak_o, ack_dest_o}); endproperty
   property p_tx_hold; tx_valid_o && !tx_ready_i |=> tx_valid_o &&
      $stable({tx_data_o, tx_message_group_number_o}); endproperty
   property p_ack_dest; ack_valid_o |-> ack_dest_o == src_ff; endproperty
   property p_tx_dest; tx_valid_o |->
      tx_message_group_number_o == {10'h17b, src_ff}; endproperty
   property p_not_global; tx_valid_o |->
      tx_message_group_number_o[7:0] != 8'hff; endproperty
   property p_byte7; tx_valid_o |-> tx_data_o[63:56] == 8'hff; endproperty
   property p_single; tx_valid_o |-> ((tx_data_o[23:16] == 8'hff) ==
      (tx_data_o[55:40] == 16'hffff)); endproperty
   property p_idle; !busy_o |-> !tx_valid_o && !ack_valid_o; endproperty
   property p_off; !enable_i && !busy_o |=> !busy_o; endproperty
   a_take_busy: assert property (p_take_busy) else $error("no busy");
   a_ack_due: assert property (p_ack_due) else $error("no ack");
   a_ack_hold: assert property (p_ack_hold) else $error("ack drop");
   a_tx_hold: assert property (p_tx_hold) else $error("report drop");
   a_ack_dest: assert property (p_ack_dest) else $error("ack dest");
   a_tx_dest: assert property (p_tx_dest) else $error("report group");
   a_not_global: assert property (p_not_global) else $error("global");
   a_byte7: assert property (p_byte7) else $error("byte7");
   a_single: assert property (p_single) else $error("single mark");
   a_idle: assert property (p_idle) else $error("unasked reply");
   a_off: assert property (p_off) else $error("taken while off");
endmodule // binding_monitor
`default_nettype wire

/* testbench/requester_model.sv */
// Requesting node: takes acks and reports, stalling when slow_i is high.
// Assumes clk_sys_i; ready changes on the falling edge only.
`timescale 1ns/1ns
`default_nettype none
module requester_model (
   input wire logic clk_sys_i,
   input wire logic slow_i,
   output logic ack_ready_o,
   output logic tx_ready_o
);
   // Internal addresses are opaque here, so nothing is decoded
   always @(negedge clk_sys_i) begin
      ack_ready_o <= !slow_i || ($urandom % 3 == 0);
      tx_ready_o <= !slow_i || ($urandom % 4 == 0);
   end
endmodule // requester_model
`default_nettype wire

/* testbench/tb.sv */
// Bench: requests in, acks and reports checked against a table mirror.
// Assumes the handler, its defines header and the requester model.
`timescale 1ns/1ns
`default_nettype none
`include "binding_defines.vh"
`define CHK(a,b,m) begin n_compared++; if ((a) !== (b)) begin bad_count++; \
$display("unexpected at %0t: %s", $time, m); end end
module tb;
   logic clk_sys_i = 1'b0, resetn_i = 1'b0, enable_i = 1'b1, slow = 1'b0;
   logic rx_valid_i = 1'b0;
   logic [7:0] node_addr_i = 8'h42, device_class_code_i = 8'h83;
   logic [7:0] inst_count_i = 8'h08, rx_src_addr_i = 8'ha0;
   logic [17:0] rx_message_group_number_i = 18'h0, req_grp;
   logic [63:0] rx_data_i = 64'h0;
   wire ack_valid_o, ack_nak_o, ack_ready_i, tx_valid_o, tx_ready_i, busy_o;
   wire [7:0] ack_dest_o;
   wire [17:0] tx_message_group_number_o;
   wire [63:0] tx_data_o;
   logic [8:0] ack_q[$];
   logic [81:0] rpt_q[$];
   logic [8:0] ack_exp;
   logic [81:0] rpt_exp;
   logic [15:0] map [0:7];
   int bad_count = 0, n_compared = 0;
   always #5 clk_sys_i = ~clk_sys_i;
   instance_binding_handler instance_binding_handler_inst (
      .clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .enable_i(enable_i),
      .node_addr_i(node_addr_i), .device_class_code_i(device_class_code_i),
      .inst_count_i(inst_count_i), .rx_valid_i(rx_valid_i),
      .rx_message_group_number_i(rx_message_group_number_i),
      .rx_src_addr_i(rx_src_addr_i), .rx_data_i(rx_data_i),
      .ack_valid_o(ack_valid_o), .ack_nak_o(ack_nak_o),
      .ack_dest_o(ack_dest_o), .ack_ready_i(ack_ready_i),
      .tx_valid_o(tx_valid_o), .tx_data_o(tx_data_o),
      .tx_message_group_number_o(tx_message_group_number_o),
      .tx_ready_i(tx_ready_i), .busy_o(busy_o));
   requester_model requester_model_inst (.clk_sys_i(clk_sys_i),
      .slow_i(slow), .ack_ready_o(ack_ready_i), .tx_ready_o(tx_ready_i));
   always @(posedge clk_sys_i) begin
      if (resetn_i && ack_valid_o === 1'b1 && ack_ready_i === 1'b1) begin
         ack_exp = ack_q.size() ? ack_q.pop_front() : 9'bx;
         `CHK({ack_nak_o, ack_dest_o}, ack_exp, "ack")
      end
      if (resetn_i && tx_valid_o === 1'b1 && tx_ready_i === 1'b1) begin
         rpt_exp = rpt_q.size() ? rpt_q.pop_front() : 82'bx;
         `CHK({tx_message_group_number_o, tx_data_o}, rpt_exp, "report")
      end
   end
   task automatic complete_run;
      if (bad_count == 0 && n_compared > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task automatic wait_idle;
      int k;
      repeat (3) @(negedge clk_sys_i);
      for (k = 0; k < 3000 && busy_o !== 1'b0; k++) @(negedge clk_sys_i);
      `CHK(busy_o, 1'b0, "hang")
      `CHK(ack_q.size() + rpt_q.size(), 0, "missing reply")
      if (busy_o !== 1'b0) complete_run;
   endtask
   // Unbound entries read back as 0xffff in the mirror
   function automatic logic [81:0] rpt(input [7:0] cls, inst, input bit one);
      logic open;
      open = one || map[inst[2:0]] === 16'hffff;
      return {`RPT_GROUP_BASE | {10'h0, rx_src_addr_i}, 8'hff,
         open ? 16'hffff : map[inst[2:0]], map[inst[2:0]],
         open ? 8'hff : inst, inst, cls};
   endfunction
   task automatic req(input [7:0] cls, base, max, input [15:0] ia, int kind);
      int i;
      if (kind < 2) ack_q.push_back({kind[0], rx_src_addr_i});
      if (kind == 1) rpt_q.push_back({`RPT_GROUP_BASE | {10'h0,
         rx_src_addr_i}, 48'hffff_ffff_ffff, base, cls});
      else if (kind == 0 && base == 8'hff)
         for (i = 0; i < 8; i++) rpt_q.push_back(rpt(cls, 8'(i), 0));
      else if (kind == 0 && (max == 8'hff || max == base)) begin
         if (ia != 16'hffff) map[base[2:0]] = ia;
         rpt_q.push_back(rpt(cls, base, 1));
      end else if (kind == 0) for (i = base; i <= max; i++) begin
         if (ia != 16'hffff) map[i] = ia + 16'(i - base);
         rpt_q.push_back(rpt(cls, 8'(i), 0));
      end
      @(negedge clk_sys_i);
      rx_valid_i = 1'b1;
      rx_message_group_number_i = req_grp;
      rx_data_i = {8'($urandom), ia + 16'(max - base), ia, max, base,
         cls};
      @(negedge clk_sys_i);
      rx_valid_i = 1'b0;
      rx_data_i = ~rx_data_i;
      wait_idle;
   endtask
   initial begin
      int n;
      void'($urandom(32'hc0a0d854));
      req_grp = `REQ_GROUP_BASE | {10'h0, node_addr_i};
      for (n = 0; n < 8; n++) map[n] = 16'hffff;
      repeat (5) @(negedge clk_sys_i);
      resetn_i = 1'b1;
      req(8'h83, 8'h03, 8'hff, 16'h1234, 0);
      req(8'h83, 8'hff, 8'hff, 16'hffff, 0);
      slow = 1'b1;
      req(8'h83, 8'h04, 8'h06, 16'h0100, 0);
      req(8'h83, 8'h02, 8'h02, 16'h0abc, 0);
      req(8'h83, 8'h05, 8'hff, 16'hffff, 0);
      req(8'h82, 8'h01, 8'hff, 16'h0010, 1);
      req(8'h83, 8'h08, 8'hff, 16'h0010, 1);
      req(8'h83, 8'h06, 8'h04, 16'h0010, 1);
      inst_count_i = 8'h00;
      req(8'h83, 8'h01, 8'hff, 16'h0010, 1);
      inst_count_i = 8'h08;
      req_grp = {10'h17d, node_addr_i};
      req(8'h83, 8'h01, 8'hff, 16'h0010, 2);
      req_grp = `REQ_GROUP_BASE | 18'h43;
      req(8'h83, 8'h01, 8'hff, 16'h0010, 2);
      req_grp = `REQ_GROUP_BASE | {10'h0, node_addr_i};
      rx_src_addr_i = 8'hff;
      req(8'h83, 8'h01, 8'hff, 16'h0010, 2);
      rx_src_addr_i = 8'h5c;
      enable_i = 1'b0;
      req(8'h83, 8'h01, 8'hff, 16'h0010, 2);
      enable_i = 1'b1;
      for (n = 0; n < 4; n++) begin
         slow = 1'($urandom);
         req(8'h83, 8'($urandom % 8), 8'hff, 16'($urandom % 'hff00), 0);
      end
      req(8'h83, 8'hff, 8'h00, 16'hffff, 0);
      complete_run;
   end
endmodule // tb
bind instance_binding_handler binding_monitor binding_monitor_inst (
   .clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .enable_i(enable_i),
   .node_addr_i(node_addr_i), .rx_valid_i(rx_valid_i),
   .rx_message_group_number_i(rx_message_group_number_i),
   .rx_src_addr_i(rx_src_addr_i), .ack_valid_o(ack_valid_o),
   .ack_nak_o(ack_nak_o), .ack_dest_o(ack_dest_o), .ack_ready_i(ack_ready_i),
   .tx_valid_o(tx_valid_o), .tx_data_o(tx_data_o), .tx_ready_i(tx_ready_i),
   .tx_message_group_number_o(tx_message_group_number_o), .busy_o(busy_o));
`default_nettype wire
